// ==== hw/jpu_pkg.sv ====
// jpu_pkg: constants and types for the test port and power-up controller.
// assumes one core clock; all test-port pins are sampled, not used as clocks.
package jpu_pkg;
	localparam int NPIN = 8; // user pins on this part
	localparam int IR_W = 8; // instruction register width
	localparam int UC_W = 32; // user code width
	localparam int CFG_W = UC_W + 2; // pull-up select, programmed mark, user code
	localparam int BSR_W = NPIN; // one boundary cell per pin
	// instruction codes
	localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
	localparam logic [IR_W-1:0] INS_IDCODE = 8'h01;
	localparam logic [IR_W-1:0] INS_INTEST = 8'h02;
	localparam logic [IR_W-1:0] INS_PRELOAD = 8'h03;
	localparam logic [IR_W-1:0] INS_CLAMP = 8'hFA;
	localparam logic [IR_W-1:0] INS_HIGHZ = 8'hFC;
	localparam logic [IR_W-1:0] INS_USERCODE = 8'hFD;
	localparam logic [IR_W-1:0] INS_BYPASS = 8'hFF;
	localparam logic [IR_W-1:0] INS_PROGRAM = 8'hEA; // nonvolatile write
	localparam logic [IR_W-1:0] INS_ERASE = 8'hED; // nonvolatile erase
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01; // fixed capture pattern
	// identity value, arbitrary
	localparam logic [31:0] ID_CODE = 32'h0A5C_0001;
	// reset values
	localparam logic [CFG_W-1:0] CFG_RESET = 34'h0_0000_0000;
	localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int CFG_LOAD_NS = 40; // nonvolatile to volatile copy
	localparam int CFG_LOAD_CYC = (CFG_LOAD_NS * CLK_MHZ + 999) / 1000;
	localparam int NV_WRITE_US = 100; // cell write/erase time
	localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
	localparam int CNT_W = 16;
	// configuration image
	typedef struct packed {
		logic pull_sel; // 1: weak pull-up in user mode, 0: no pull
		logic programmed; // 0 when erased
		logic [UC_W-1:0] usercode;
	} jpu_cfg_s;
	// sampled test-port pins
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jpu_tap_s;
	typedef enum logic [3:0] {
		TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
		TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
	} jpu_tap_e;
	typedef enum logic [1:0] {PS_QUIET, PS_LOAD, PS_ERASED, PS_USER} jpu_pwr_e;
endpackage : jpu_pkg

// ==== hw/jpu_top.sv ====
// jpu_top: test-access port, boundary scan and power-up state control.
// assumes tck/tms/tdi and the supply-good level arrive from pins (synchronised here);
// core_out/core_oe come from same-clock core logic. tck must be well under clk/4.
//
// Overview of operation
// - all-ones instruction selects one-bit bypass
// - all-zero instruction drives boundary cells onto pins
// - code 03 captures core data into cells
// - code 02 feeds cell data to core inputs
// - code FC floats every output
// - code FA holds output values caught at entry, with every pin driven
// - nonvolatile programming through test-port commands
// - programming finishes well inside one second
// - copy configuration at power-up, pins disabled
// - stay quiescent until core supply is safe
// - quiescent: port off, outputs off, pulled high
// - leaving quiescent initialises registers, runs after the 40 ns configuration copy
// - erased part: outputs off, port enabled
// - programmed part: configured I/O, port enabled
// - inputs and logic live only in user operation
`timescale 1ns/1ps
module jpu_top
	import jpu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tck, // test clock pin, sampled
	input wire logic tms,
	input wire logic tdi,
	output logic tdo_o, // test data out
	output logic tdo_oe, // high while shifting
	input wire logic supply_ok, // core_supply_rail above the safe level
	input wire logic [NPIN-1:0] pin_i, // pin_buffer_cell receive side
	output logic [NPIN-1:0] pin_o, // pin_buffer_cell drive value
	output logic [NPIN-1:0] pin_oe, // pin_buffer_cell drive enable
	output logic [NPIN-1:0] pin_pull_en, // weak pull-up enable
	input wire logic [NPIN-1:0] core_out, // user logic outputs
	input wire logic [NPIN-1:0] core_oe, // user logic output enables
	output logic [NPIN-1:0] core_in, // inputs seen by user logic
	output logic core_run, // function blocks and clocks enabled
	output logic tap_en, // test controller enabled
	output logic nv_busy // nonvolatile write or erase in progress
);
	// two-stage synchronisers; stage one is read only by stage two
	jpu_tap_s tap_s1_q, tap_s2_q;
	logic sup_s1_q, sup_s2_q;
	logic [NPIN-1:0] pin_s1_q, pin_s2_q;
	logic tck_prev_q; // for edge finding
	logic tck_rise, tck_fall;

	jpu_tap_e ts_q, ts_d; // tap state
	jpu_pwr_e ps_q; // power-up state
	logic [IR_W-1:0] ir_sh_q, ir_q; // shift and active instruction
	logic byp_q; // bypass cell
	logic [31:0] id_sh_q; // identity/user code shifter
	logic [BSR_W-1:0] bsr_sh_q, bsr_upd_q; // boundary shift and update stages
	logic [CFG_W-1:0] prog_sh_q; // programming data shifter
	logic [NPIN-1:0] clamp_q; // held values for clamp
	jpu_cfg_s nv_q; // nonvolatile image
	jpu_cfg_s cfg_q; // volatile configuration cells
	logic [CNT_W-1:0] load_cnt_q, nv_cnt_q;
	logic erase_pend_q;
	logic dr_tdo; // serial out of the selected data register

	// synchronise every pin that comes from outside
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tap_s1_q <= '0;
			tap_s2_q <= '0;
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			tap_s1_q <= '{tck: tck, tms: tms, tdi: tdi};
			tap_s2_q <= tap_s1_q;
			sup_s1_q <= supply_ok;
			sup_s2_q <= sup_s1_q;
			pin_s1_q <= pin_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	// edge finder on the synchronised test clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= tap_s2_q.tck;
		end
	end
	assign tck_rise = tap_s2_q.tck & ~tck_prev_q & tap_en;
	assign tck_fall = ~tap_s2_q.tck & tck_prev_q & tap_en;

	// power-up sequencing: quiet until supply good, copy, then erased or user
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ps_q <= PS_QUIET;
			load_cnt_q <= '0;
			cfg_q <= CFG_RESET;
		end else if (!sup_s2_q) begin
			ps_q <= PS_QUIET; // supply sag returns to quiescent
			load_cnt_q <= '0;
		end else begin
			unique case (ps_q)
				PS_QUIET: begin
					ps_q <= PS_LOAD;
					load_cnt_q <= '0;
				end
				PS_LOAD: begin
					cfg_q <= nv_q; // nonvolatile bits into volatile cells
					load_cnt_q <= load_cnt_q + 1'b1;
					if (load_cnt_q == CNT_W'(CFG_LOAD_CYC - 1)) begin
						ps_q <= nv_q.programmed ? PS_USER : PS_ERASED;
					end
				end
				PS_ERASED, PS_USER: begin
					// a fresh image takes effect only after the next power-up
					ps_q <= ps_q;
				end
			endcase
		end
	end

	// port enable: off only while quiescent or copying
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tap_en <= 1'b0;
		end else begin
			tap_en <= (ps_q == PS_ERASED) || (ps_q == PS_USER);
		end
	end

	// tap next-state table
	always_comb begin
		ts_d = ts_q;
		unique case (ts_q)
			TS_RESET: ts_d = tap_s2_q.tms ? TS_RESET : TS_IDLE;
			TS_IDLE: ts_d = tap_s2_q.tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_DR: ts_d = tap_s2_q.tms ? TS_SEL_IR : TS_CAP_DR;
			TS_CAP_DR: ts_d = tap_s2_q.tms ? TS_EX1_DR : TS_SH_DR;
			TS_SH_DR: ts_d = tap_s2_q.tms ? TS_EX1_DR : TS_SH_DR;
			TS_EX1_DR: ts_d = tap_s2_q.tms ? TS_UPD_DR : TS_PA_DR;
			TS_PA_DR: ts_d = tap_s2_q.tms ? TS_EX2_DR : TS_PA_DR;
			TS_EX2_DR: ts_d = tap_s2_q.tms ? TS_UPD_DR : TS_SH_DR;
			TS_UPD_DR: ts_d = tap_s2_q.tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_IR: ts_d = tap_s2_q.tms ? TS_RESET : TS_CAP_IR;
			TS_CAP_IR: ts_d = tap_s2_q.tms ? TS_EX1_IR : TS_SH_IR;
			TS_SH_IR: ts_d = tap_s2_q.tms ? TS_EX1_IR : TS_SH_IR;
			TS_EX1_IR: ts_d = tap_s2_q.tms ? TS_UPD_IR : TS_PA_IR;
			TS_PA_IR: ts_d = tap_s2_q.tms ? TS_EX2_IR : TS_PA_IR;
			TS_EX2_IR: ts_d = tap_s2_q.tms ? TS_UPD_IR : TS_SH_IR;
			TS_UPD_IR: ts_d = tap_s2_q.tms ? TS_SEL_DR : TS_IDLE;
		endcase
	end

	// tap state register; held in reset while the port is disabled
	always_ff @(posedge clk) begin
		if (sys_rst || !tap_en) begin
			ts_q <= TS_RESET;
		end else if (tck_rise) begin
			ts_q <= ts_d;
		end
	end

	// instruction register: capture, shift lsb first, update
	always_ff @(posedge clk) begin
		if (sys_rst || !tap_en || ts_q == TS_RESET) begin
			ir_sh_q <= IR_CAPTURE;
			ir_q <= IR_RESET;
		end else if (tck_rise) begin
			if (ts_q == TS_CAP_IR) begin
				ir_sh_q <= IR_CAPTURE;
			end else if (ts_q == TS_SH_IR) begin
				ir_sh_q <= {tap_s2_q.tdi, ir_sh_q[IR_W-1:1]};
			end else if (ts_q == TS_UPD_IR) begin
				ir_q <= ir_sh_q;
			end
		end
	end

	// hold-value register for clamp, caught as the instruction takes effect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clamp_q <= '0;
		end else if (tck_rise && ts_q == TS_UPD_IR && ir_sh_q == INS_CLAMP) begin
			clamp_q <= pin_o;
		end
	end

	// bypass cell, also used for clamp and highz
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byp_q <= 1'b0;
		end else if (tck_rise) begin
			if (ts_q == TS_CAP_DR) begin
				byp_q <= 1'b0;
			end else if (ts_q == TS_SH_DR) begin
				byp_q <= tap_s2_q.tdi;
			end
		end
	end

	// identity shifter: fixed code or programmed user code
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			id_sh_q <= '0;
		end else if (tck_rise) begin
			if (ts_q == TS_CAP_DR) begin
				id_sh_q <= (ir_q == INS_USERCODE) ? cfg_q.usercode : ID_CODE;
			end else if (ts_q == TS_SH_DR) begin
				id_sh_q <= {tap_s2_q.tdi, id_sh_q[31:1]};
			end
		end
	end

	// boundary register: capture pins or core data, shift, update
	// only the boundary instructions may disturb the cells, so a bypass or id scan keeps driven values
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bsr_sh_q <= '0;
			bsr_upd_q <= '0;
		end else if (tck_rise && (ir_q == INS_EXTEST || ir_q == INS_INTEST || ir_q == INS_PRELOAD)) begin
			if (ts_q == TS_CAP_DR) begin
				// preload and intest sample core data; extest samples the pins
				bsr_sh_q <= (ir_q == INS_EXTEST) ? pin_s2_q : core_out;
			end else if (ts_q == TS_SH_DR) begin
				bsr_sh_q <= {tap_s2_q.tdi, bsr_sh_q[BSR_W-1:1]};
			end else if (ts_q == TS_UPD_DR) begin
				bsr_upd_q <= bsr_sh_q;
			end
		end
	end

	// programming shifter and nonvolatile image with write timer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prog_sh_q <= '0;
			nv_q <= CFG_RESET;
			nv_cnt_q <= '0;
			nv_busy <= 1'b0;
			erase_pend_q <= 1'b0;
		end else begin
			if (nv_busy) begin
				nv_cnt_q <= nv_cnt_q - 1'b1; // bounded write time
				nv_busy <= (nv_cnt_q != CNT_W'(1));
			end
			if (tck_rise && ts_q == TS_SH_DR && ir_q == INS_PROGRAM) begin
				prog_sh_q <= {tap_s2_q.tdi, prog_sh_q[CFG_W-1:1]};
			end
			if (tck_rise && !nv_busy && ts_q == TS_UPD_DR && ir_q == INS_PROGRAM) begin
				nv_q <= prog_sh_q;
				nv_busy <= 1'b1;
				nv_cnt_q <= CNT_W'(NV_WRITE_CYC);
			end
			// erase runs at the first test clock rise after entering idle under the erase instruction;
			// the mark follows test clock rises, not core clocks, or it is gone before the next rise
			if (tck_rise) begin
				erase_pend_q <= (ts_q != TS_IDLE);
			end
			if (tck_rise && !nv_busy && erase_pend_q && ts_q == TS_IDLE && ir_q == INS_ERASE) begin
				nv_q <= CFG_RESET;
				nv_busy <= 1'b1;
				nv_cnt_q <= CNT_W'(NV_WRITE_CYC);
			end
		end
	end

	// selected data register output
	always_comb begin
		unique case (ir_q)
			INS_EXTEST, INS_INTEST, INS_PRELOAD: dr_tdo = bsr_sh_q[0];
			INS_IDCODE, INS_USERCODE: dr_tdo = id_sh_q[0];
			INS_PROGRAM: dr_tdo = prog_sh_q[0];
			default: dr_tdo = byp_q; // bypass, clamp, highz, unknown codes
		endcase
	end

	// test data out changes on the falling test clock
	always_ff @(posedge clk) begin
		if (sys_rst || !tap_en) begin
			tdo_o <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_o <= (ts_q == TS_SH_IR) ? ir_sh_q[0] : dr_tdo;
			tdo_oe <= (ts_q == TS_SH_IR) || (ts_q == TS_SH_DR);
		end
	end

	// pin drivers: test instructions override configured behaviour
	always_ff @(posedge clk) begin
		if (sys_rst || ps_q == PS_QUIET || ps_q == PS_LOAD) begin
			pin_o <= '0;
			pin_oe <= '0;
			pin_pull_en <= '1;
		end else if (ir_q == INS_EXTEST) begin
			pin_o <= bsr_upd_q;
			pin_oe <= '1;
			pin_pull_en <= '0;
		end else if (ir_q == INS_HIGHZ) begin
			pin_o <= '0;
			pin_oe <= '0;
			pin_pull_en <= '0;
		end else if (ir_q == INS_CLAMP) begin
			pin_o <= clamp_q;
			pin_oe <= '1;
			pin_pull_en <= '0;
		end else if (ps_q == PS_ERASED) begin
			pin_o <= '0;
			pin_oe <= '0;
			pin_pull_en <= '1;
		end else begin
			pin_o <= core_out;
			pin_oe <= core_oe;
			pin_pull_en <= {NPIN{cfg_q.pull_sel}};
		end
	end

	// core side: live only in user operation; intest substitutes cell data
	always_ff @(posedge clk) begin
		if (sys_rst || ps_q != PS_USER) begin
			core_in <= '0;
			core_run <= 1'b0;
		end else begin
			core_in <= (ir_q == INS_INTEST) ? bsr_upd_q : pin_s2_q;
			core_run <= 1'b1;
		end
	end
endmodule : jpu_top

// ==== tb/jpu_tap_master.sv ====
// jpu_tap_master: behavioural test master on the far side of the test port.
// assumes tasks are entered on a falling clk edge; tck rests low between frames.
`timescale 1ns/1ps
module jpu_tap_master (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_o,
	input wire logic tdo_oe
);
	logic tdo_w; // level seen on the tdo wire
	// a released wire shows the inverse of the last bit, so a stale bit never passes
	assign tdo_w = tdo_oe ? tdo_o : ~tdo_o;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one test clock of 160 ns, far below the speed limit; tdo taken before the rise
	task step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80;
		o = tdo_w;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask : step
	// five ones reach reset from any state, then park in idle
	task tap_reset();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask : tap_reset
	// idle to idle scan, lsb first; the last bit leaves the shift state
	task scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask : scan
endmodule : jpu_tap_master

// ==== tb/jpu_top_checker.sv ====
// jpu_top_checker: port-level properties of the test port and power-up control.
// assumes one clk domain with synchronous active-high sys_rst; bound into jpu_top.
`timescale 1ns/1ps
module jpu_top_checker
	import jpu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic supply_ok,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	input wire logic [NPIN-1:0] pin_oe,
	input wire logic [NPIN-1:0] pin_pull_en,
	input wire logic [NPIN-1:0] core_in,
	input wire logic core_run,
	input wire logic tap_en,
	input wire logic nv_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// port off means quiescent or loading: pins must float high
	AST_OFF_PINS: assert property (!tap_en ##1 !tap_en |-> pin_oe == '0 && pin_pull_en == '1)
		else $error("pins active while test port off");
	AST_OFF_TDO: assert property (!tap_en ##1 !tap_en |-> !tdo_oe)
		else $error("tdo driven while test port off");
	// sync delay is two flops, so six low cycles is ample
	AST_SUPPLY_LOW: assert property (!supply_ok [*6] |-> !tap_en && !core_run)
		else $error("active while supply low");
	AST_CORE_IN: assert property (!core_run ##1 !core_run |-> core_in == '0)
		else $error("core inputs live outside user mode");
	AST_BUSY_HOLD: assert property ($rose(nv_busy) |-> nv_busy [*8])
		else $error("write busy dropped early");
	// tdo only moves after the test clock has fallen
	AST_TDO_AT_FALL: assert property (tap_en && $changed(tdo_o) |-> !tck)
		else $error("tdo changed with test clock high");
	AST_TDO_OE_FALL: assert property ($rose(tdo_oe) |-> !tck && tap_en)
		else $error("tdo enable rose off a falling edge");
	AST_RUN_TAP: assert property (core_run ##1 core_run |-> tap_en)
		else $error("user mode without test port");
	COV_RUN: cover property ($rose(core_run));
	COV_BUSY: cover property ($rose(nv_busy));
	COV_SHIFT: cover property ($rose(tdo_oe));
endmodule : jpu_top_checker

bind jpu_top jpu_top_checker jpu_top_checker_inst (.*);

// ==== tb/test_jpu_top.sv ====
// test_jpu_top: scenario bench for the test port and power-up control.
// assumes the tap master model drives the test pins; other inputs change at falling clk.
`timescale 1ns/1ps
module test_jpu_top
	import jpu_pkg::*;
;
	localparam logic [31:0] UC = 32'h1234_5678; // user code written by the bench
	logic clk, sys_rst, supply_ok, tck, tms, tdi, tdo_o, tdo_oe, core_run, tap_en, nv_busy;
	logic [NPIN-1:0] pin_i, pin_o, pin_oe, pin_pull_en, core_out, core_oe, core_in;
	logic [63:0] dout; // last scan result
	int n_mismatch, comparisons;
	always #2 clk = ~clk;
	jpu_top jpu_top_inst (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .supply_ok(supply_ok), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe(pin_oe), .pin_pull_en(pin_pull_en), .core_out(core_out), .core_oe(core_oe),
		.core_in(core_in), .core_run(core_run), .tap_en(tap_en), .nv_busy(nv_busy));
	jpu_tap_master jpu_tap_master_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
	task check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task sc(input logic ir, input logic [63:0] d, input int n);
		jpu_tap_master_inst.scan(ir, d, n, dout);
	endtask : sc
	// drop the supply, check the quiescent state, raise it and wait for the port
	task power();
		int i;
		supply_ok = 1'b0;
		repeat (20) @(negedge clk);
		check(tap_en, 1'b0);
		check({pin_oe, pin_pull_en}, 16'h00FF);
		check(core_run, 1'b0);
		supply_ok = 1'b1;
		for (i = 0; i < 200 && tap_en !== 1'b1; i++)
			@(negedge clk);
		if (tap_en !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
		jpu_tap_master_inst.tap_reset();
	endtask : power
	task t_power();
		power();
		check({core_run, pin_oe, pin_pull_en}, 17'h000FF);
		$display("t_power done");
	endtask : t_power
	task t_id();
		sc(1'b1, INS_IDCODE, IR_W);
		check(dout[7:0], IR_CAPTURE);
		sc(1'b0, 64'h0, 32);
		check(dout[31:0], ID_CODE);
		$display("t_id done");
	endtask : t_id
	task t_bypass();
		sc(1'b1, INS_BYPASS, IR_W);
		sc(1'b0, 64'hA5, 9);
		check(dout[8:0], {8'hA5, 1'b0});
		$display("t_bypass done");
	endtask : t_bypass
	// cells preloaded, driven, clamped, then floated
	task t_bound();
		core_out = 8'h96;
		sc(1'b1, INS_PRELOAD, IR_W);
		sc(1'b0, 64'h3C, 8);
		check(dout[7:0], 8'h96);
		sc(1'b1, INS_EXTEST, IR_W);
		check({pin_o, pin_oe}, 16'h3CFF);
		pin_i = 8'hC3;
		sc(1'b0, 64'h3C, 8);
		check(dout[7:0], 8'hC3);
		check({pin_o, pin_oe}, 16'h3CFF);
		sc(1'b1, INS_CLAMP, IR_W);
		check({pin_o, pin_oe}, 16'h3CFF);
		sc(1'b1, INS_HIGHZ, IR_W);
		check({pin_oe, pin_pull_en}, 16'h0000);
		$display("t_bound done");
	endtask : t_bound
	// bounded wait for a nonvolatile write or erase; a hang goes straight to the report
	task wait_nv();
		int i;
		for (i = 0; i < 30000 && nv_busy !== 1'b0; i++)
			@(negedge clk);
		check(nv_busy, 1'b0);
		if (nv_busy !== 1'b0)
			stop_test();
	endtask : wait_nv
	// program, wait out the write, power cycle into user mode
	task t_prog();
		sc(1'b1, INS_PROGRAM, IR_W);
		sc(1'b0, {30'h0, 2'h3, UC}, 34);
		check(nv_busy, 1'b1);
		wait_nv();
		power();
		check({core_run, tap_en}, 2'h3);
		check(core_in, 8'hC3);
		sc(1'b1, INS_USERCODE, IR_W);
		sc(1'b0, 64'h0, 32);
		check(dout[31:0], UC);
		sc(1'b1, INS_INTEST, IR_W);
		sc(1'b0, 64'h5A, 8);
		check(core_in, 8'h5A);
		$display("t_prog done");
	endtask : t_prog
	// erase, wait it out, power cycle back into the erased state
	task t_erase();
		sc(1'b1, INS_ERASE, IR_W);
		jpu_tap_master_inst.tap_reset(); // first rise in idle starts the erase
		check(nv_busy, 1'b1);
		wait_nv();
		power();
		check({core_run, tap_en, pin_oe, pin_pull_en}, 18'h100FF);
		$display("t_erase done");
	endtask : t_erase
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		supply_ok = 1'b0;
		core_out = 8'h00;
		core_oe = 8'hFF;
		pin_i = 8'h00;
		n_mismatch = 0;
		comparisons = 0;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		t_power();
		t_id();
		t_bypass();
		t_bound();
		t_prog();
		t_erase();
		stop_test();
	end
endmodule : test_jpu_top
